/* rtl/pcache_stat_counters.sv */
// Overview of operation
// R01: Count cacheable fetch or load hits
// R02: Count cacheable instruction fetch misses only
// R03: Count automatic prefetch aborts
// R04: Non-cacheable accesses leave hit, miss alone
// R05: All counters readable, writable, no reset value
// R06: Wrap at all ones; write beats increment
`timescale 1ns/1ps
`default_nettype none
`include "pcache_stat_params.svh"

module pcache_stat_counters (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire pcache_stat_pkg::cache_event_t cache_ev,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [`ADDR_W-1:0]          paddr,
    input  wire logic [`DATA_W-1:0]          pwdata,
    output var  logic                        pready,
    output var  logic [`DATA_W-1:0]          prdata,
    output var  logic                        pslverr
);

    // Map a bus address to a counter index, or none
    function automatic logic [`NUM_TALLIES-1:0] decode(input logic [`ADDR_W-1:0] a);
        logic [`NUM_TALLIES-1:0] sel;
        sel = '0;
        unique case (a)
            `HIT_TALLY_ADDR:   sel[`HIT_IDX]   = 1'b1;
            `MISS_TALLY_ADDR:  sel[`MISS_IDX]  = 1'b1;
            `ABORT_TALLY_ADDR: sel[`ABORT_IDX] = 1'b1;
            default:           sel = '0;
        endcase
        return sel;
    endfunction

    logic [`NUM_TALLIES-1:0] bump;
    logic [`NUM_TALLIES-1:0] sel;
    logic [`NUM_TALLIES-1:0] wr_sel;
    logic [`DATA_W-1:0]      count [`NUM_TALLIES];
    logic                    access;

    // Event qualification
    assign bump[`HIT_IDX]   = cache_ev.cacheable & cache_ev.hit
                              & (cache_ev.fetch | cache_ev.load);         // [R01] [R04]
    assign bump[`MISS_IDX]  = cache_ev.cacheable & ~cache_ev.hit
                              & cache_ev.fetch;                           // [R02] [R04]
    assign bump[`ABORT_IDX] = cache_ev.pf_abort;                          // [R03]

    // Bus decode; access phase completes in two cycles, one wait state
    assign access = psel & penable & ~pready;
    assign sel    = decode(paddr);
    assign wr_sel = (access & pwrite) ? sel : '0;

    // Three counters
    genvar i;
    generate
        for (i = 0; i < `NUM_TALLIES; i++) begin : g_tally
            tally_counter u_tally (
                .mclk       (mclk),
                .bump       (bump[i]),
                .load       (wr_sel[i]),                                  // [R05]
                .load_value (pwdata),
                .count      (count[i])
            );
        end
    endgenerate

    // Ready pulse, after one wait-state access cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= access;
        end
    end

    // Read data and error for unmapped addresses
    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata  <= `ZERO_WORD;
            pslverr <= 1'b0;
        end else if (access) begin
            pslverr <= ~|sel;
            prdata  <= `ZERO_WORD;
            if (!pwrite) begin
                unique case (1'b1)
                    sel[`HIT_IDX]:   prdata <= count[`HIT_IDX];           // [R05]
                    sel[`MISS_IDX]:  prdata <= count[`MISS_IDX];          // [R05]
                    sel[`ABORT_IDX]: prdata <= count[`ABORT_IDX];         // [R05]
                    default:         prdata <= `ZERO_WORD;
                endcase
            end
        end else begin
            pslverr <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* rtl/pcache_stat_params.svh */
`ifndef PCACHE_STAT_PARAMS_SVH
`define PCACHE_STAT_PARAMS_SVH

// Register byte addresses on the APB
`define HIT_TALLY_ADDR   12'h000
`define MISS_TALLY_ADDR  12'h004
`define ABORT_TALLY_ADDR 12'h008
`define ADDR_W           12
`define DATA_W           32
`define ZERO_WORD        32'h00000000
`define ONE_WORD         32'h00000001
`define NUM_TALLIES      3
`define HIT_IDX          0
`define MISS_IDX         1
`define ABORT_IDX        2

`endif

/* rtl/pcache_stat_pkg.sv */
package pcache_stat_pkg;

    // One cycle of cache activity from the fetch and load path
    typedef struct packed {
        logic fetch;        // Instruction fetch issued
        logic load;         // Data load issued
        logic cacheable;    // Access targets a cacheable region
        logic hit;          // Access hit the prefetch cache
        logic pf_abort;     // Automatic prefetch cancelled
    } cache_event_t;

    // APB request fields
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

/* rtl/tally_counter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcache_stat_params.svh"

// One 32-bit statistics counter, software write over increment
module tally_counter (
    input  wire logic                 mclk,
    input  wire logic                 bump,
    input  wire logic                 load,
    input  wire logic [`DATA_W-1:0]   load_value,
    output var  logic [`DATA_W-1:0]   count
);

    // No reset: counter value is undefined until written
    always_ff @(posedge mclk) begin
        if (load) begin
            count <= load_value;             // [R06]
        end else if (bump) begin
            count <= count + `ONE_WORD;      // [R06]
        end
    end

endmodule
`default_nettype wire

/* testbench/fetch_path_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fetch_path_model (
    input  wire logic                          mclk,
    input  wire pcache_stat_pkg::cache_event_t want,
    output var  pcache_stat_pkg::cache_event_t ev
);
    // Issue the requested access as one cycle
    always_ff @(posedge mclk) begin
        ev <= want;
    end
endmodule
`default_nettype wire

/* testbench/stat_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module stat_monitor (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Access phase still waiting
    sequence acc_wait; psel && penable && !pready; endsequence
    AST_ONE_WAIT: assert property (acc_wait |=> pready) else $error("late ready");
    AST_CAUSE: assert property (pready |-> $past(penable)) else $error("stray ready");
    AST_PULSE: assert property (pready |=> !pready) else $error("long ready");
    AST_ERR: assert property (pslverr |-> pready) else $error("stray error");
    AST_WR_ZERO: assert property (pready && pwrite |-> prdata == '0) else $error("data");
    AST_ERR_ZERO: assert property (pslverr |-> prdata == '0) else $error("err data");
endmodule
bind pcache_stat_counters stat_monitor u_stat_monitor (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata));
`default_nettype wire

/* testbench/tb_pcache_stat_counters.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcache_stat_params.svh"
module tb_pcache_stat_counters;
    logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, er;
    pcache_stat_pkg::cache_event_t want = 5'h00, ev;
    int fails = 0, comparisons = 0;
    fetch_path_model u_fetch_path_model (.mclk(mclk), .want(want), .ev(ev));
    pcache_stat_counters u_pcache_stat_counters (.mclk(mclk), .rst(rst), .cache_ev(ev),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    initial begin
        forever #10 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer, waits for ready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            fails++;
            tally_and_finish();
        end
        @(posedge mclk);
    endtask
    task automatic sc_rw;
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, 12'(i * 4), 32'hA5C3F00F ^ 32'(i));
            xfer(1'b0, 12'(i * 4), 32'h00000000);
            chk(rd, 32'hA5C3F00F ^ 32'(i), "readback");
        end
        xfer(1'b0, 12'h00C, 32'h00000000);
        chk({31'h00000000, er}, 32'h00000001, "unmapped error");
    endtask
    task automatic sc_count;
        logic [4:0] evs [7] = '{5'h16, 5'h0E, 5'h14, 5'h0C, 5'h12, 5'h10, 5'h01};
        xfer(1'b1, `HIT_TALLY_ADDR, 32'hFFFFFFFF);
        xfer(1'b1, `MISS_TALLY_ADDR, 32'hFFFFFFFF);
        xfer(1'b1, `ABORT_TALLY_ADDR, 32'h12345678);
        foreach (evs[i]) begin
            want <= evs[i];
            @(posedge mclk);
            want <= 5'h00;
            repeat (2) @(posedge mclk);
        end
        xfer(1'b0, `HIT_TALLY_ADDR, 32'h00000000);
        chk(rd, 32'h00000001, "hit");
        xfer(1'b0, `MISS_TALLY_ADDR, 32'h00000000);
        chk(rd, 32'h00000000, "miss");
        xfer(1'b0, `ABORT_TALLY_ADDR, 32'h00000000);
        chk(rd, 32'h12345679, "abort");
        // Hit event lands on the same edge as the write
        want <= 5'h16;
        fork
            xfer(1'b1, `HIT_TALLY_ADDR, 32'h0000BEEF);
            begin
                @(posedge mclk);
                want <= 5'h00;
            end
        join
        xfer(1'b0, `HIT_TALLY_ADDR, 32'h00000000);
        chk(rd, 32'h0000BEEF, "write over bump");
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        sc_rw();
        sc_count();
        tally_and_finish();
    end
    // Watchdog
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
